//--- logic/ps2_mouse_receiver.sv
// Purpose: receive pointing device frames and assemble movement reports
// Assumes: mouse_clk is the device's link clock, still between frames
// Notes: link side shifts on mouse_clk falling edges, bytes cross by toggle
//
// How it works
// - A frame has start, eight payload bits, parity and stop, eleven slots.
// - Payload bits arrive least significant first, after the start bit.
// - Start must be low and stop high; a low stop marks the byte bad.
// - Payload plus parity must hold an odd count of ones.
// - The first report byte has bit 3 set and bit 2 clear, used to align.
// - Header bits 0 and 1 give the two button states, one when held.
// - Header bits 4 and 5 give the horizontal and vertical signs.
// - Header bits 6 and 7 give the horizontal and vertical overflows.
// - Byte two is horiz_delta and byte three is vert_delta.
// - Right and up are positive, left and down negative.
`timescale 1ns/1ps
module ps2_mouse_receiver
    import mouse_rx_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int BUF_DEPTH = BUF_D
) (
    // System side
    input wire logic ref_clk,
    input wire logic rst,
    // Link from the device
    input wire logic mouse_clk,
    input wire logic mouse_data,
    // Report out
    output logic report_valid,
    input wire logic report_ready,
    output logic button_one,
    output logic button_two,
    output logic horiz_sign,
    output logic vert_sign,
    output logic horiz_ovf,
    output logic vert_ovf,
    output logic [7:0] horiz_delta,
    output logic [7:0] vert_delta,
    output logic [8:0] horiz_move,
    output logic [8:0] vert_move,
    // Status
    output logic frame_err
);
    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(TIMEOUT_CYCLES - 1);

    // Link domain
    logic link_clr_reg;
    logic link_init_reg;
    logic [3:0] slot_reg;
    logic [7:0] shift_reg;
    logic par_reg;
    logic [9:0] word_reg;
    logic tgl_reg;

    // Slot counter; stays at start until a low start bit
    always_ff @(negedge mouse_clk or posedge link_clr_reg) begin
        if (link_clr_reg) begin
            slot_reg <= SLOT_START;
        end else if (slot_reg == SLOT_START) begin
            if (!mouse_data) begin
                slot_reg <= SLOT_D0;
            end
        end else if (slot_reg == SLOT_STOP) begin
            slot_reg <= SLOT_START;
        end else begin
            slot_reg <= slot_reg + 4'h1;
        end
    end

    // Data is stable at the falling edge, so it is taken directly
    always_ff @(negedge mouse_clk or posedge link_clr_reg) begin
        if (link_clr_reg) begin
            shift_reg <= 8'h00;
        end else if (slot_reg >= SLOT_D0 && slot_reg <= SLOT_D7) begin
            shift_reg <= {mouse_data, shift_reg[7:1]};
        end
    end

    always_ff @(negedge mouse_clk or posedge link_clr_reg) begin
        if (link_clr_reg) begin
            par_reg <= 1'b0;
        end else if (slot_reg == SLOT_PAR) begin
            par_reg <= mouse_data;
        end
    end

    // Word and toggle survive a timeout clear, so no false byte appears
    always_ff @(negedge mouse_clk or posedge link_init_reg) begin
        if (link_init_reg) begin
            word_reg <= 10'h000;
            tgl_reg <= 1'b0;
        end else if (slot_reg == SLOT_STOP) begin
            word_reg <= {mouse_data, par_reg, shift_reg};
            tgl_reg <= ~tgl_reg;
        end
    end

    // System domain: synchronisers
    logic mclk_s1_reg, mclk_s2_reg;
    logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
    logic new_byte;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mclk_s1_reg <= 1'b1;
            mclk_s2_reg <= 1'b1;
        end else begin
            mclk_s1_reg <= mouse_clk;
            mclk_s2_reg <= mclk_s1_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_s3_reg <= 1'b0;
        end else begin
            tgl_s1_reg <= tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
        end
    end

    assign new_byte = tgl_s2_reg ^ tgl_s3_reg;

    // Silence watch; the limit exceeds a full 50 us period
    logic [IDLE_W-1:0] idle_reg;
    logic timeout;

    assign timeout = mclk_s2_reg && (idle_reg == IDLE_LAST);

    always_ff @(posedge ref_clk) begin
        if (rst || !mclk_s2_reg) begin
            idle_reg <= '0;
        end else if (idle_reg != IDLE_W'(TIMEOUT_CYCLES)) begin
            idle_reg <= idle_reg + 1'b1;
        end
    end

    // Clear pulse for the link side; its clock is idle high then
    always_ff @(posedge ref_clk) begin
        link_clr_reg <= rst || timeout;
        link_init_reg <= rst;
    end

    // Hold a byte until the buffer has room
    logic pend_reg;
    logic [9:0] cap_reg;
    logic full, empty, push, pop;
    logic [ENT_W-1:0] ent_in;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_reg <= 1'b0;
            cap_reg <= 10'h000;
        end else if (new_byte) begin
            pend_reg <= 1'b1;
            cap_reg <= word_reg;
        end else if (push) begin
            pend_reg <= 1'b0;
        end
    end

    // Limitation: a byte landing while one is pending replaces it
    assign push = pend_reg && !full;
    assign ent_in = {!(^cap_reg[WORD_PAR:0]) || !cap_reg[WORD_STOP],
                     cap_reg[7:0]};

    // Two-entry byte buffer
    logic [ENT_W-1:0] mem_reg [BUF_DEPTH];
    logic [PW-1:0] wr_reg, rd_reg;
    logic [PW:0] cnt_reg;
    logic [ENT_W-1:0] ent_out;

    assign full = (cnt_reg == (PW+1)'(BUF_DEPTH));
    assign empty = (cnt_reg == '0);
    assign ent_out = mem_reg[rd_reg];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= ent_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == PW'(BUF_DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == PW'(BUF_DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Report assembly; a held report stalls the buffer
    rep_state_t state_reg;
    logic [7:0] hdr_reg, hx_reg;
    logic hdr_ok;

    assign pop = !empty && !report_valid;
    assign hdr_ok = ent_out[HDR_ONE] && !ent_out[HDR_ZERO];

    always_ff @(posedge ref_clk) begin
        if (rst || timeout) begin
            state_reg <= ST_B0;
        end else if (pop) begin
            if (ent_out[ENT_ERR]) begin
                state_reg <= ST_B0;
            end else begin
                case (state_reg)
                    ST_B0: state_reg <= hdr_ok ? ST_B1 : ST_B0;
                    ST_B1: state_reg <= ST_B2;
                    ST_B2: state_reg <= ST_B0;
                    default: state_reg <= ST_B0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hdr_reg <= 8'h00;
            hx_reg <= 8'h00;
        end else if (pop && !ent_out[ENT_ERR]) begin
            if (state_reg == ST_B0) begin
                hdr_reg <= ent_out[7:0];
            end
            if (state_reg == ST_B1) begin
                hx_reg <= ent_out[7:0];
            end
        end
    end

    logic rep_done;
    assign rep_done = pop && !ent_out[ENT_ERR] && (state_reg == ST_B2);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            report_valid <= 1'b0;
        end else if (rep_done) begin
            report_valid <= 1'b1;
        end else if (report_ready) begin
            report_valid <= 1'b0;
        end
    end

    // Fields update only as a whole report
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            button_one <= 1'b0;
            button_two <= 1'b0;
            horiz_sign <= 1'b0;
            vert_sign <= 1'b0;
            horiz_ovf <= 1'b0;
            vert_ovf <= 1'b0;
            horiz_delta <= 8'h00;
            vert_delta <= 8'h00;
            horiz_move <= 9'h000;
            vert_move <= 9'h000;
        end else if (rep_done) begin
            button_one <= hdr_reg[HDR_BTN1];
            button_two <= hdr_reg[HDR_BTN2];
            horiz_sign <= hdr_reg[HDR_HSIGN];
            vert_sign <= hdr_reg[HDR_VSIGN];
            horiz_ovf <= hdr_reg[HDR_HOVF];
            vert_ovf <= hdr_reg[HDR_VOVF];
            horiz_delta <= hx_reg;
            vert_delta <= ent_out[7:0];
            horiz_move <= {hdr_reg[HDR_HSIGN], hx_reg};
            vert_move <= {hdr_reg[HDR_VSIGN], ent_out[7:0]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            frame_err <= 1'b0;
        end else begin
            frame_err <= pop && ent_out[ENT_ERR];
        end
    end

    // Checks on the link side
    property p_start_low;
        @(negedge mouse_clk) disable iff (link_clr_reg)
        (slot_reg == SLOT_START) && mouse_data |=> (slot_reg == SLOT_START);
    endproperty
    chk_start_bit_low: assert property (p_start_low)
        else $error("high start bit began a frame");

    property p_stop_wrap;
        @(negedge mouse_clk) disable iff (link_clr_reg)
        (slot_reg == SLOT_STOP) |=> (slot_reg == SLOT_START) && (slot_reg <= SLOT_STOP);
    endproperty
    chk_eleven_slots: assert property (p_stop_wrap)
        else $error("frame did not end after stop slot");

    property p_lsb_first;
        @(negedge mouse_clk) disable iff (link_clr_reg)
        (slot_reg == SLOT_PAR) |->
            shift_reg[7] == $past(mouse_data) && shift_reg[0] == $past(mouse_data, 8);
    endproperty
    chk_lsb_first_order: assert property (p_lsb_first)
        else $error("payload bits out of order");

    // Checks on the system side
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_parity_stop_flag: assert property (push |->
        ent_in[ENT_ERR] == ((^cap_reg[7:0] == cap_reg[WORD_PAR]) || !cap_reg[WORD_STOP]))
        else $error("parity or stop check wrong");

    chk_header_align: assert property (
        pop && !ent_out[ENT_ERR] && state_reg == ST_B0 && !hdr_ok |=> state_reg == ST_B0)
        else $error("bad header accepted");

    sequence s_bad_pop;
        pop && ent_out[ENT_ERR];
    endsequence
    sequence s_realign;
        frame_err && state_reg == ST_B0;
    endsequence
    chk_error_realign: assert property (s_bad_pop |=> s_realign)
        else $error("bad byte did not realign");

    chk_timeout_clear: assert property (timeout |=> link_clr_reg && state_reg == ST_B0)
        else $error("timeout did not clear frame");

    chk_byte_capture: assert property (new_byte && !push |=> pend_reg ##1 1'b1)
        else $error("crossed byte lost");

    sequence s_last_byte;
        rep_done;
    endsequence
    chk_vert_field: assert property (s_last_byte |=>
        report_valid && vert_delta == $past(ent_out[7:0]) && horiz_delta == $past(hx_reg))
        else $error("report fields wrong");

    chk_report_hold: assert property (report_valid && !report_ready |=>
        report_valid && $stable(button_one) && $stable(horiz_move))
        else $error("report changed while held");

    chk_signed_move: assert property (
        rep_done |=> vert_move[8] == $past(hdr_reg[HDR_VSIGN]) && horiz_move[8] == horiz_sign)
        else $error("movement sign wrong");
endmodule

//--- inc/mouse_rx_pkg.sv
// Purpose: shared constants for the pointing device receiver
// Assumes: system clock of 250 MHz
// Notes: frame slots count from the start bit
package mouse_rx_pkg;
    // Frame slots on the link
    localparam logic [3:0] SLOT_START = 4'h0;
    localparam logic [3:0] SLOT_D0 = 4'h1;
    localparam logic [3:0] SLOT_D7 = 4'h8;
    localparam logic [3:0] SLOT_PAR = 4'h9;
    localparam logic [3:0] SLOT_STOP = 4'ha;
    // Captured word layout {stop, parity, payload_bits}
    localparam int WORD_PAR = 8;
    localparam int WORD_STOP = 9;
    // First report byte fields
    localparam int HDR_BTN1 = 0;
    localparam int HDR_BTN2 = 1;
    localparam int HDR_ZERO = 2;
    localparam int HDR_ONE = 3;
    localparam int HDR_HSIGN = 4;
    localparam int HDR_VSIGN = 5;
    localparam int HDR_HOVF = 6;
    localparam int HDR_VOVF = 7;
    // Buffer entry layout {error, byte}
    localparam int ENT_ERR = 8;
    localparam int ENT_W = 9;
    localparam int BUF_D = 2;
    // Link silence timeout
    localparam int SYS_MHZ = 250;
    localparam int TIMEOUT_US = 100;
    localparam int TIMEOUT_CYC = TIMEOUT_US * SYS_MHZ;
    localparam int IDLE_W = 16;
    // Report assembly states
    typedef enum logic [2:0] {
        ST_B0 = 3'b001,
        ST_B1 = 3'b010,
        ST_B2 = 3'b100
    } rep_state_t;
endpackage

//--- dv/mouse_link_model.sv
// Purpose: behavioural pointing device driving the two-wire link
// Assumes: link clock period 12 ns, clock still between frames
// Notes: parity and stop bit can be corrupted on request
`timescale 1ns/1ps
module mouse_link_model (
    // Link to the receiver
    output logic mouse_clk,
    output logic mouse_data
);
    initial begin
        mouse_clk = 1'b1;
        mouse_data = 1'b1;
    end

    // One frame; data moves half a period ahead of each fall
    task automatic send_byte(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic [10:0] f;
        f = {~bad_stop, (~^d) ^ bad_par, d, 1'b0};
        #1.3;
        for (int i = 0; i < 11; i++) begin
            mouse_data = f[i];
            #6 mouse_clk = 1'b0;
            #6 mouse_clk = 1'b1;
        end
        // Released line must not keep showing the stop level
        #6 mouse_data = ~f[10];
    endtask
endmodule

//--- dv/testbench.sv
// Purpose: self-checking bench for the pointing device receiver
// Assumes: short silence timeout of 200 cycles
// Notes: gaps inside a report stay well under the timeout
`timescale 1ns/1ps
module testbench;
    import mouse_rx_pkg::*;
    typedef struct {
        logic [7:0] b0, b1, b2;
        logic [8:0] hm, vm;
    } row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic report_ready = 1'b0;
    logic mouse_clk, mouse_data;
    logic report_valid, button_one, button_two, horiz_sign, vert_sign;
    logic horiz_ovf, vert_ovf, frame_err;
    logic [7:0] horiz_delta, vert_delta;
    logic [8:0] horiz_move, vert_move;
    logic [8:0] err_pulses = 9'h000;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    row_t rows[4] = '{
        '{8'h09, 8'h05, 8'h02, 9'h005, 9'h002},
        '{8'h3a, 8'hfd, 8'hf0, 9'h1fd, 9'h1f0},
        '{8'hc8, 8'h7f, 8'h80, 9'h07f, 9'h080},
        '{8'h1b, 8'h00, 8'hff, 9'h100, 9'h0ff}
    };

    mouse_link_model mdl (.mouse_clk(mouse_clk), .mouse_data(mouse_data));
    ps2_mouse_receiver #(.TIMEOUT_CYCLES(200), .BUF_DEPTH(2)) DUT (
        .ref_clk(ref_clk), .rst(rst), .mouse_clk(mouse_clk), .mouse_data(mouse_data),
        .report_valid(report_valid), .report_ready(report_ready),
        .button_one(button_one), .button_two(button_two),
        .horiz_sign(horiz_sign), .vert_sign(vert_sign),
        .horiz_ovf(horiz_ovf), .vert_ovf(vert_ovf),
        .horiz_delta(horiz_delta), .vert_delta(vert_delta),
        .horiz_move(horiz_move), .vert_move(vert_move), .frame_err(frame_err));

    always #2 ref_clk = ~ref_clk;

    // Error pulses last one cycle, so count them as they pass
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (frame_err === 1'b1) begin
            err_pulses <= err_pulses + 9'h001;
        end
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %0t run too long", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [8:0] got, input logic [8:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic send_rep(input row_t r);
        mdl.send_byte(r.b0, 1'b0, 1'b0);
        #40 mdl.send_byte(r.b1, 1'b0, 1'b0);
        #40 mdl.send_byte(r.b2, 1'b0, 1'b0);
    endtask

    task automatic wait_valid();
        int n;
        n = 0;
        @(negedge ref_clk);
        while (report_valid !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        chk_bit(report_valid, 1'b1, "report offered");
    endtask

    task automatic chk_rep(input row_t r);
        chk_bit(button_one, r.b0[HDR_BTN1], "button one");
        chk_bit(button_two, r.b0[HDR_BTN2], "button two");
        chk_bit(horiz_sign, r.b0[HDR_HSIGN], "horiz sign");
        chk_bit(vert_sign, r.b0[HDR_VSIGN], "vert sign");
        chk_bit(horiz_ovf, r.b0[HDR_HOVF], "horiz ovf");
        chk_bit(vert_ovf, r.b0[HDR_VOVF], "vert ovf");
        chk_vec({1'b0, horiz_delta}, {1'b0, r.b1}, "horiz delta");
        chk_vec({1'b0, vert_delta}, {1'b0, r.b2}, "vert delta");
        chk_vec(horiz_move, r.hm, "horiz move");
        chk_vec(vert_move, r.vm, "vert move");
    endtask

    task automatic take_rep();
        report_ready = 1'b1;
        @(negedge ref_clk);
        report_ready = 1'b0;
        chk_bit(report_valid, 1'b0, "valid after take");
    endtask

    initial begin
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk_bit(report_valid, 1'b0, "valid at reset");
        chk_vec(horiz_move, 9'h000, "move at reset");
        repeat (4) @(negedge ref_clk);
        // Ordinary reports, one per row
        foreach (rows[i]) begin
            send_rep(rows[i]);
            wait_valid();
            chk_rep(rows[i]);
            take_rep();
        end
        // Bad parity mid report drops it and realigns
        mdl.send_byte(rows[0].b0, 1'b0, 1'b0);
        #40 mdl.send_byte(8'h55, 1'b1, 1'b0);
        #40 send_rep(rows[1]);
        wait_valid();
        chk_rep(rows[1]);
        chk_vec(err_pulses, 9'h001, "parity error pulse");
        take_rep();
        // Low stop bit is a malformed byte
        mdl.send_byte(rows[2].b0, 1'b0, 1'b0);
        #40 mdl.send_byte(8'h12, 1'b0, 1'b1);
        #40 send_rep(rows[3]);
        wait_valid();
        chk_rep(rows[3]);
        chk_vec(err_pulses, 9'h002, "stop error pulse");
        take_rep();
        // Byte without the header marks is not a header
        mdl.send_byte(8'h00, 1'b0, 1'b0);
        #40 send_rep(rows[2]);
        wait_valid();
        chk_rep(rows[2]);
        take_rep();
        // Silent link drops a partial report
        mdl.send_byte(rows[0].b0, 1'b0, 1'b0);
        #40 mdl.send_byte(8'h33, 1'b0, 1'b0);
        repeat (300) @(negedge ref_clk);
        send_rep(rows[1]);
        wait_valid();
        chk_rep(rows[1]);
        take_rep();
        // Consumer stalls while the next bytes queue up
        send_rep(rows[0]);
        wait_valid();
        mdl.send_byte(rows[3].b0, 1'b0, 1'b0);
        #40 mdl.send_byte(rows[3].b1, 1'b0, 1'b0);
        repeat (40) @(negedge ref_clk);
        chk_bit(report_valid, 1'b1, "valid held in stall");
        chk_rep(rows[0]);
        take_rep();
        mdl.send_byte(rows[3].b2, 1'b0, 1'b0);
        wait_valid();
        chk_rep(rows[3]);
        take_rep();
        // Reset in mid-run while a report is offered
        send_rep(rows[0]);
        wait_valid();
        rst = 1'b1;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk_bit(report_valid, 1'b0, "valid after mid reset");
        chk_vec(vert_move, 9'h000, "move after mid reset");
        repeat (4) @(negedge ref_clk);
        send_rep(rows[2]);
        wait_valid();
        chk_rep(rows[2]);
        take_rep();
        final_report();
    end
endmodule
